// ---- bth_host_port.sv ----
// Command and status port of the multi-channel bit-error tester.
// Assumes the command bus comes from logic on the same clock and is held
// for at least two cycles per command.
`timescale 1ns/100ps
module bth_host_port #(
    parameter int NUM_IDX = 16,
    parameter logic [bth_pkg::MASTER_W-1:0] TX_MASTER_RIGHT = 4'h0,
    parameter logic [bth_pkg::MASTER_W-1:0] TX_MASTER_LEFT = 4'h0,
    parameter logic GREF_OPTION = 1'b0,
    parameter logic OWN_TX_CLOCK = 1'b0,
    parameter logic FABRIC_LOOPBACK = 1'b0,
    parameter logic [bth_pkg::PAT_W-1:0] PATTERN_MASK = 16'hFFFF
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Command bus from the I/O peripheral
    input bth_pkg::bth_cmd_t cmd_in,
    // Status words of the datapath, one per index
    input wire logic [(1<<bth_pkg::IDX_W)-1:0][bth_pkg::STAT_W-1:0] ext_status_in,
    // Configuration port handshake of the selected transceiver
    input wire logic config_ready_in,
    input wire logic config_access_enable_in,
    // Status bus to the I/O peripheral
    output logic [bth_pkg::STAT_W-1:0] status_out,
    // Selections and stored control words
    output logic [bth_pkg::LANE_W-1:0] lane_pair_select_out,
    output logic transceiver_select_out,
    output logic config_ready_sticky_out,
    output logic [NUM_IDX-1:0][bth_pkg::CTRL_W-1:0] ctrl_bank_out
);

    // Whole state of the port
    typedef struct packed
    {
        logic [bth_pkg::LANE_W-1:0] lane;  // Lane pair selection
        logic xcvr;                        // Transceiver selection
        logic rdy;                         // Sticky config ready
        logic rd_pend;                     // Read captured, output next
        logic [bth_pkg::STAT_W-1:0] rd_word; // Captured status word
        logic [bth_pkg::STAT_W-1:0] status;  // Presented status word
    } bth_port_state_t;

    bth_port_state_t st_r;
    bth_port_state_t st_nxt;

    logic wr_hit;     // Write command to a writable index
    logic rd_hit;     // Read command
    logic [bth_pkg::STAT_W-1:0] opt_word; // Options word of index 6
    logic [bth_pkg::STAT_W-1:0] sel_ext;  // Datapath word at command index

    // Elaboration checks
    if (NUM_IDX <= int'(bth_pkg::IDX_OPTIONS) || NUM_IDX > (1 << bth_pkg::IDX_W))
    begin : g_bad_idx
        $error("bth_host_port index count out of range");
    end

    // Selection fields must fit inside the control word
    if (bth_pkg::XCVR_BIT >= bth_pkg::CTRL_W
        || bth_pkg::LANE_LSB + bth_pkg::LANE_W > bth_pkg::CTRL_W)
    begin : g_bad_fields
        $error("bth_host_port selection fields outside control word");
    end

    // Op code decode, shared by write and read paths
    function automatic logic op_is(input logic [bth_pkg::OP_W-1:0] op,
                                   input logic [bth_pkg::OP_W-1:0] code);
        op_is = (op == code);
    endfunction

    // Decode; any other op code stores nothing and starts no read
    always_comb
    begin
        wr_hit = op_is(cmd_in.op, bth_pkg::OP_WRITE)
                 && cmd_in.idx != bth_pkg::IDX_OPTIONS;
        rd_hit = op_is(cmd_in.op, bth_pkg::OP_READ);
        sel_ext = ext_status_in[cmd_in.idx];
    end

    // Options word built from the sticky bit and build constants
    always_comb
    begin
        opt_word = bth_pkg::STAT_RST;
        opt_word[bth_pkg::RDY_BIT] = st_r.rdy;
        opt_word[bth_pkg::MR_LSB +: bth_pkg::MASTER_W] = TX_MASTER_RIGHT;
        opt_word[bth_pkg::ML_LSB +: bth_pkg::MASTER_W] = TX_MASTER_LEFT;
        opt_word[bth_pkg::GREF_BIT] = GREF_OPTION;
        opt_word[bth_pkg::OWNCLK_BIT] = OWN_TX_CLOCK;
        opt_word[bth_pkg::FLB_BIT] = FABRIC_LOOPBACK;
        opt_word[bth_pkg::PAT_LSB +: bth_pkg::PAT_W] = PATTERN_MASK;
    end

    // Next-state logic
    always_comb
    begin
        st_nxt = st_r;
        // Selections follow index 0 writes only
        if (wr_hit && cmd_in.idx == bth_pkg::IDX_SELECT)
        begin
            st_nxt.lane = cmd_in.ctrl[bth_pkg::LANE_LSB +: bth_pkg::LANE_W];
            st_nxt.xcvr = cmd_in.ctrl[bth_pkg::XCVR_BIT];
        end
        // Sticky ready: a completed access sets, the next enable clears
        if (config_ready_in)
        begin
            st_nxt.rdy = 1'b1;
        end
        else if (config_access_enable_in)
        begin
            st_nxt.rdy = 1'b0;
        end
        // First read stage captures the addressed word
        st_nxt.rd_pend = rd_hit;
        if (rd_hit)
        begin
            // Options index is built here, never taken from the datapath
            if (cmd_in.idx == bth_pkg::IDX_OPTIONS)
            begin
                st_nxt.rd_word = opt_word;
            end
            // Datapath word of a populated index
            else if (int'(cmd_in.idx) < NUM_IDX)
            begin
                st_nxt.rd_word = sel_ext;
            end
            // Unpopulated index reads as zero
            else
            begin
                st_nxt.rd_word = bth_pkg::STAT_RST;
            end
        end
        // Second stage presents it; otherwise the bus holds
        if (st_r.rd_pend)
        begin
            st_nxt.status = st_r.rd_word;
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Control word storage; index 6 writes never reach it
    bth_ctrl_bank #(
        .NUM_IDX(NUM_IDX),
        .WORD_W(bth_pkg::CTRL_W)
    ) u_bank (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .wr_en_in(wr_hit),
        .wr_idx_in(cmd_in.idx),
        .wr_data_in(cmd_in.ctrl),
        .words_out(ctrl_bank_out)
    );

    // Outputs straight from flip-flops
    assign status_out = st_r.status;
    assign lane_pair_select_out = st_r.lane;
    assign transceiver_select_out = st_r.xcvr;
    assign config_ready_sticky_out = st_r.rdy;

    // Datapath word reaches the status bus two edges after the read
    a_read_latency: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (rd_hit && cmd_in.idx != bth_pkg::IDX_OPTIONS && int'(cmd_in.idx) < NUM_IDX)
        |-> ##2 status_out == $past(sel_ext, 2))
        else $error("status word not presented two cycles after read");

    // Clock master channel numbers of both columns
    a_opts_fields: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (rd_hit && cmd_in.idx == bth_pkg::IDX_OPTIONS)
        |-> ##2 (status_out[bth_pkg::MR_LSB +: bth_pkg::MASTER_W] == TX_MASTER_RIGHT
        && status_out[bth_pkg::ML_LSB +: bth_pkg::MASTER_W] == TX_MASTER_LEFT))
        else $error("clock master fields wrong in options word");

    // Build option flags in their fixed order
    a_opts_flags: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (rd_hit && cmd_in.idx == bth_pkg::IDX_OPTIONS)
        |-> ##2 status_out[15:13] == {FABRIC_LOOPBACK, OWN_TX_CLOCK, GREF_OPTION})
        else $error("build option flags wrong in options word");

    // Pattern mask in the upper half, reserved bits clear
    a_opts_pattern: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (rd_hit && cmd_in.idx == bth_pkg::IDX_OPTIONS)
        |-> ##2 (status_out[31:16] == PATTERN_MASK && status_out[4:1] == 4'h0))
        else $error("pattern mask or reserved bits wrong");

    // Status bus only moves when a captured read is presented
    a_status_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !st_r.rd_pend |=> $stable(status_out))
        else $error("status bus changed without a read");

    // Selections hold unless index 0 is written
    a_sel_idx0_only: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !(wr_hit && cmd_in.idx == bth_pkg::IDX_SELECT)
        |=> ($stable(lane_pair_select_out) && $stable(transceiver_select_out)))
        else $error("selection changed without an index 0 write");

    // Lane selection agrees with the stored index 0 word
    a_sel_update: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (op_is(cmd_in.op, bth_pkg::OP_WRITE) && cmd_in.idx == bth_pkg::IDX_SELECT)
        |=> lane_pair_select_out == ctrl_bank_out[0][bth_pkg::LANE_W-1:0])
        else $error("lane pair selection not taken from index 0 write");

    // Completed access sets the sticky bit
    a_sticky_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
        config_ready_in |=> config_ready_sticky_out)
        else $error("sticky ready not set by completed access");

    // Next access enable clears the sticky bit
    a_sticky_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (config_access_enable_in && !config_ready_in) |=> !config_ready_sticky_out)
        else $error("sticky ready not cleared by next enable");

    // Unused op codes store nothing and start no read
    a_other_ops: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!op_is(cmd_in.op, bth_pkg::OP_WRITE) && !op_is(cmd_in.op, bth_pkg::OP_READ))
        |=> ($stable(ctrl_bank_out) && !st_r.rd_pend))
        else $error("unknown op code changed state");

    // Options index is read-only
    a_opts_readonly: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (cmd_in.op == bth_pkg::OP_WRITE && cmd_in.idx == bth_pkg::IDX_OPTIONS)
        |=> $stable(ctrl_bank_out))
        else $error("write to options index stored a word");

    // Further checks on selections, sticky bit, control bank and the read pipeline

    // Lane pair selection follows an index 0 write
    a_lane_update: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (op_is(cmd_in.op, bth_pkg::OP_WRITE) && cmd_in.idx == bth_pkg::IDX_SELECT)
        |=> lane_pair_select_out == $past(cmd_in.ctrl[bth_pkg::LANE_LSB +: bth_pkg::LANE_W]))
        else $error("lane pair selection differs from index 0 write");

    // Transceiver selection follows an index 0 write
    a_xcvr_update: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (op_is(cmd_in.op, bth_pkg::OP_WRITE) && cmd_in.idx == bth_pkg::IDX_SELECT)
        |=> transceiver_select_out == $past(cmd_in.ctrl[bth_pkg::XCVR_BIT]))
        else $error("transceiver selection differs from index 0 write");

    // Sticky bit holds with neither ready nor enable
    a_sticky_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!config_ready_in && !config_access_enable_in) |=> $stable(config_ready_sticky_out))
        else $error("sticky ready moved without ready or enable");

    // Ready in the same cycle as an enable still sets
    a_sticky_priority: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (config_ready_in && config_access_enable_in) |=> config_ready_sticky_out)
        else $error("enable overrode a completed access");

    // Options word bit 0 shows the sticky bit of the last capture
    a_opts_ready_bit: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ((rd_hit && cmd_in.idx == bth_pkg::IDX_OPTIONS) ##1 !rd_hit)
        |-> ##1 status_out[bth_pkg::RDY_BIT] == $past(config_ready_sticky_out, 2))
        else $error("options word ready bit differs from sticky bit");

    // A write leaves the presented status alone
    a_write_keeps_status: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (op_is(cmd_in.op, bth_pkg::OP_WRITE) && !st_r.rd_pend) |=> $stable(status_out))
        else $error("write moved the status bus");

    // A write never starts a read
    a_write_no_pend: assert property (@(posedge clk_in) disable iff (!nrst_in)
        op_is(cmd_in.op, bth_pkg::OP_WRITE) |=> !st_r.rd_pend)
        else $error("write started a read");

    // No control word is ever kept at the options index
    a_opts_bank_empty: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ctrl_bank_out[bth_pkg::IDX_OPTIONS] == bth_pkg::CTRL_RST)
        else $error("control word stored at options index");

    // First read stage captures the addressed datapath word
    a_read_stage1: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (rd_hit && cmd_in.idx != bth_pkg::IDX_OPTIONS && int'(cmd_in.idx) < NUM_IDX)
        |=> (st_r.rd_pend && st_r.rd_word == $past(sel_ext)))
        else $error("read stage one did not capture the word");

    // Second read stage presents the captured word
    a_read_stage2: assert property (@(posedge clk_in) disable iff (!nrst_in)
        st_r.rd_pend |=> status_out == $past(st_r.rd_word))
        else $error("read stage two did not present the word");

    // Unused op codes leave the status bus alone
    a_other_ops_status: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!op_is(cmd_in.op, bth_pkg::OP_WRITE) && !op_is(cmd_in.op, bth_pkg::OP_READ)
        && !st_r.rd_pend) |=> $stable(status_out))
        else $error("unknown op code moved the status bus");

    // Unused op codes leave both selections alone
    a_other_ops_sel: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (!op_is(cmd_in.op, bth_pkg::OP_WRITE) && !op_is(cmd_in.op, bth_pkg::OP_READ))
        |=> ($stable(lane_pair_select_out) && $stable(transceiver_select_out)))
        else $error("unknown op code moved a selection");

endmodule

// ---- bth_pkg.sv ----
// Constants, field layouts and carrier types of the bit-error tester host port.
// Assumes one control-plane clock shared by the port and the I/O peripheral.
package bth_pkg;

    // Command bus layout
    localparam int CMD_W = 32;
    localparam int OP_W = 2;
    localparam int IDX_W = 4;
    localparam int CTRL_W = CMD_W - OP_W - IDX_W;
    localparam int STAT_W = 32;

    // Operation codes
    localparam logic [OP_W-1:0] OP_WRITE = 2'h3;
    localparam logic [OP_W-1:0] OP_READ = 2'h1;

    // Index map
    localparam logic [IDX_W-1:0] IDX_SELECT = 4'h0;
    localparam logic [IDX_W-1:0] IDX_OPTIONS = 4'h6;

    // Selection fields inside the index 0 control word
    localparam int LANE_LSB = 0;
    localparam int LANE_W = 4;
    localparam int XCVR_BIT = 4;

    // Options status word field positions
    localparam int RDY_BIT = 0;
    localparam int RSV_LSB = 1;
    localparam int RSV_W = 4;
    localparam int MASTER_W = 4;
    localparam int MR_LSB = 5;
    localparam int ML_LSB = 9;
    localparam int GREF_BIT = 13;
    localparam int OWNCLK_BIT = 14;
    localparam int FLB_BIT = 15;
    localparam int PAT_LSB = 16;
    localparam int PAT_W = 16;

    // Reset values
    localparam logic [STAT_W-1:0] STAT_RST = 32'h0000_0000;
    localparam logic [LANE_W-1:0] LANE_RST = 4'h0;
    localparam logic [CTRL_W-1:0] CTRL_RST = 26'h000_0000;

    // Read latency in clock cycles at 100 MHz (10 ns period)
    localparam int CLK_PERIOD_NS = 10;
    localparam int READ_LAT = 2;

    // Command carried from the I/O peripheral
    typedef struct packed
    {
        logic [OP_W-1:0] op;
        logic [IDX_W-1:0] idx;
        logic [CTRL_W-1:0] ctrl;
    } bth_cmd_t;

endpackage

// ---- bth_ctrl_bank.sv ----
// Bank of control words, one per command index.
// Assumes the write strobe is already qualified for op code and index.
`timescale 1ns/100ps
module bth_ctrl_bank #(
    parameter int NUM_IDX = 16,
    parameter int WORD_W = bth_pkg::CTRL_W
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic nrst_in,
    // Write port
    input wire logic wr_en_in,
    input wire logic [bth_pkg::IDX_W-1:0] wr_idx_in,
    input wire logic [WORD_W-1:0] wr_data_in,
    // Stored words
    output logic [NUM_IDX-1:0][WORD_W-1:0] words_out
);

    // Whole state of the bank
    typedef struct packed
    {
        logic [NUM_IDX-1:0][WORD_W-1:0] words; // One word per index
        logic [bth_pkg::IDX_W-1:0] chk_idx; // Index on the write port last cycle, for checking
        logic [WORD_W-1:0] chk_data; // Data on the write port last cycle, for checking
        logic chk_wr; // Last cycle held a storing write
    } bth_bank_state_t;

    bth_bank_state_t st_r;
    bth_bank_state_t st_nxt;

    // Elaboration check on depth
    if (NUM_IDX < 1 || NUM_IDX > (1 << bth_pkg::IDX_W))
    begin : g_bad_depth
        $error("bth_ctrl_bank depth out of range");
    end

    // Store the word at its index; it holds until rewritten
    always_comb
    begin
        st_nxt = st_r;
        // Remember the last write so the storage check can look back
        st_nxt.chk_idx = wr_idx_in;
        st_nxt.chk_data = wr_data_in;
        st_nxt.chk_wr = wr_en_in && int'(wr_idx_in) < NUM_IDX;
        if (st_nxt.chk_wr)
        begin
            st_nxt.words[wr_idx_in] = wr_data_in;
        end
    end

    // State register
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign words_out = st_r.words;

    a_word_stored: assert property (@(posedge clk_in) disable iff (!nrst_in)
        st_r.chk_wr |-> words_out[st_r.chk_idx] == st_r.chk_data)
        else $error("control word not stored at its index");

    a_bank_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
        !wr_en_in |=> $stable(words_out))
        else $error("control bank changed without a write");

endmodule

// ---- bth_gpio_model.sv ----
// Model of the general-purpose I/O peripheral that drives the command bus.
// Assumes the port samples on the rising edge; this model drives on falling edges.
`timescale 1ns/100ps
module bth_gpio_model
(
    // Clock
    input wire logic clk_in,
    // Command bus toward the port
    output bth_pkg::bth_cmd_t cmd_out,
    // Status bus from the port
    input wire logic [bth_pkg::STAT_W-1:0] status_in
);
    // Idle op code until the first command
    initial cmd_out = '0;

    // One command: drive, sample status one edge in, release after two edges, sample it again
    task automatic xfer(input logic [bth_pkg::OP_W-1:0] op,
                        input logic [bth_pkg::IDX_W-1:0] idx,
                        input logic [bth_pkg::CTRL_W-1:0] ctrl,
                        output logic [bth_pkg::STAT_W-1:0] early,
                        output logic [bth_pkg::STAT_W-1:0] late);
        begin
            @(negedge clk_in);
            cmd_out <= {op, idx, ctrl};
            @(negedge clk_in);
            // One edge after the request: old status must still stand
            early = status_in;
            @(negedge clk_in);
            // Released: idle op code with every other line inverted
            cmd_out <= {2'h0, ~idx, ~ctrl};
            @(negedge clk_in);
            late = status_in;
        end
    endtask
endmodule

// ---- bth_host_port_tb_top.sv ----
// Self-checking bench of the bit-error tester host port.
// Assumes the I/O peripheral model sits on the command and status buses.
`timescale 1ns/100ps
module bth_host_port_tb_top;
    // Stimulus and observation signals
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    bth_pkg::bth_cmd_t cmd;
    logic [15:0][31:0] ext_st;
    logic rdy = 1'b0;
    logic en = 1'b0;
    logic [31:0] stat;
    logic [3:0] lane;
    logic xcvr;
    logic sticky;
    logic [15:0][25:0] bank;
    logic [31:0] e;
    logic [31:0] l;
    logic [31:0] prev;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    // Free-running 100 MHz clock
    always #5 clk_in = ~clk_in;

    // Port under test with non-default build options
    bth_host_port #(.TX_MASTER_RIGHT(4'hA), .TX_MASTER_LEFT(4'h5),
        .GREF_OPTION(1'b1), .FABRIC_LOOPBACK(1'b1),
        .PATTERN_MASK(16'hC35A)) dut_u (
        .clk_in(clk_in), .nrst_in(nrst_in), .cmd_in(cmd), .ext_status_in(ext_st),
        .config_ready_in(rdy), .config_access_enable_in(en), .status_out(stat),
        .lane_pair_select_out(lane), .transceiver_select_out(xcvr),
        .config_ready_sticky_out(sticky), .ctrl_bank_out(bank));

    // Peripheral model driving the command bus
    bth_gpio_model gpio_u (.clk_in(clk_in), .cmd_out(cmd), .status_in(stat));

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        begin
            check_count++;
            if (got !== exp)
            begin
                num_errors++;
                $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
            end
        end
    endtask

    // Closing report
    task automatic print_verdict();
        begin
            $display("errors %0d checks %0d", num_errors, check_count);
            if (num_errors == 0 && check_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    // Control write
    task automatic wr(input logic [3:0] idx, input logic [25:0] ctrl);
        gpio_u.xfer(bth_pkg::OP_WRITE, idx, ctrl, e, l);
    endtask

    // Status read: old value one edge in, new value after two
    task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
        begin
            gpio_u.xfer(bth_pkg::OP_READ, idx, 26'h000_0000, e, l);
            chk(e, prev, "status too early");
            chk(l, exp, "status read");
            prev = exp;
        end
    endtask

    // Options word as laid out for this build
    function automatic logic [31:0] opt(input logic s);
        opt = {16'hC35A, 1'b1, 1'b0, 1'b1, 4'h5, 4'hA, 4'h0, s};
    endfunction

    // Hang guard
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            num_errors++;
            print_verdict();
        end
    end

    // Main sequence
    initial
    begin
        for (int i = 0; i < 16; i++)
            ext_st[i] = 32'h5A00_0000 | 32'(i * 17);
        prev = 32'h0000_0000;
        repeat (4) @(negedge clk_in);
        nrst_in = 1'b1;
        chk(stat, 32'h0000_0000, "reset status");
        chk({27'h0, xcvr, lane}, 32'h0000_0000, "reset select");
        // Writes to indices 1 to 7 but 6 leave the selections alone
        for (int i = 1; i < 8; i++)
        begin
            if (i != 6)
            begin
                wr(4'(i), 26'h100_0000 + 26'(i * 3));
                chk(32'(bank[i]), 32'(26'h100_0000 + 26'(i * 3)), "bank");
                chk({27'h0, xcvr, lane}, 32'h0000_0000, "select moved");
            end
        end
        wr(4'h0, 26'h2AA_AA15);
        chk({27'h0, xcvr, lane}, 32'h0000_0015, "select");
        // Reads of datapath words after the selection write
        for (int i = 1; i < 8; i++)
        begin
            if (i != 6)
                rd(4'(i), ext_st[i]);
        end
        wr(4'h3, 26'h000_0123);
        chk(stat, prev, "write moved status");
        chk(32'(bank[3]), 32'h0000_0123, "rewrite");
        // Unused op codes change nothing
        for (int op = 0; op < 4; op += 2)
        begin
            gpio_u.xfer(2'(op), 4'h1, 26'h3FF_FFFF, e, l);
            chk(32'(bank[1]), 32'(26'h100_0003), "ignored op wrote");
            chk(l, prev, "ignored op read");
        end
        // Options word is read-only
        rd(4'h6, opt(1'b0));
        wr(4'h6, 26'h3FF_FFFF);
        chk(32'(bank[6]), 32'h0000_0000, "options written");
        rd(4'h6, opt(1'b0));
        // Sticky ready: set, hold, clear by enable, set wins over enable
        rdy = 1'b1;
        @(negedge clk_in);
        rdy = 1'b0;
        chk(32'(sticky), 32'h0000_0001, "sticky set");
        @(negedge clk_in);
        chk(32'(sticky), 32'h0000_0001, "sticky hold");
        en = 1'b1;
        @(negedge clk_in);
        chk(32'(sticky), 32'h0000_0000, "sticky clear");
        rdy = 1'b1;
        @(negedge clk_in);
        rdy = 1'b0;
        en = 1'b0;
        chk(32'(sticky), 32'h0000_0001, "sticky priority");
        rd(4'h6, opt(1'b1));
        // Mid-run reset clears status, selections, bank and sticky bit
        @(negedge clk_in);
        nrst_in = 1'b0;
        @(negedge clk_in);
        nrst_in = 1'b1;
        chk(stat, 32'h0000_0000, "reset status again");
        chk({26'h0, sticky, xcvr, lane} | 32'(bank[3]), 32'h0000_0000, "reset state again");
        print_verdict();
    end
endmodule
